// ===== hdl/lp_rtc_pkg.sv
// shared constants, register map and types of the low power real time counter
package lp_rtc_pkg;

   // bus and data widths
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int BYTE_W  = 8;
   localparam int CNT_W   = 16;
   localparam int LVL_W   = 2;
   localparam int IDX_W   = 4;
   localparam int IDX_LSB = 2;
   localparam int PRE_W   = 10;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL     = 4'h0;
   localparam logic [IDX_W-1:0] IDX_STATUS   = 4'h1;
   localparam logic [IDX_W-1:0] IDX_IRQ_LVL  = 4'h2;
   localparam logic [IDX_W-1:0] IDX_FLAGS    = 4'h3;
   localparam logic [IDX_W-1:0] IDX_LATCH    = 4'h4;
   localparam logic [IDX_W-1:0] IDX_CNT_LO   = 4'h8;
   localparam logic [IDX_W-1:0] IDX_CNT_HI   = 4'h9;
   localparam logic [IDX_W-1:0] IDX_TOP_LO   = 4'hA;
   localparam logic [IDX_W-1:0] IDX_TOP_HI   = 4'hB;
   localparam logic [IDX_W-1:0] IDX_MATCH_LO = 4'hC;
   localparam logic [IDX_W-1:0] IDX_MATCH_HI = 4'hD;

   // field positions
   localparam int DIV_W          = 3;
   localparam int MATCH_LVL_LSB  = 2;
   localparam int WRAP_LVL_LSB   = 0;
   localparam int MATCH_FLAG_BIT = 1;
   localparam int WRAP_FLAG_BIT  = 0;
   localparam int BUSY_BIT       = 0;

   // pending write mask bits
   localparam int MASK_W     = 4;
   localparam int MASK_CTRL  = 0;
   localparam int MASK_CNT   = 1;
   localparam int MASK_TOP   = 2;
   localparam int MASK_MATCH = 3;

   // reset values
   localparam logic [CNT_W-1:0]   CNT_RST     = 16'h0000;
   localparam logic [CNT_W-1:0]   TOP_RST     = 16'hffff;
   localparam logic [CNT_W-1:0]   MATCH_RST   = 16'hffff;
   localparam logic [BYTE_W-1:0]  LATCH_RST   = 8'h00;
   localparam logic [2*LVL_W-1:0] IRQ_LVL_RST = 4'h0;

   // event thinning limits and reference-cycle latency of a synchronised write
   localparam logic [1:0] THIN_TOP0       = 2'h2;
   localparam logic [1:0] THIN_TOP1       = 2'h1;
   localparam logic [1:0] THIN_NONE       = 2'h0;
   localparam int         SYNC_REF_CYCLES = 2;
   localparam logic [1:0] SYNC_LAST       = 2'(SYNC_REF_CYCLES - 1);

   typedef enum logic [DIV_W-1:0] {
      DIV_OFF, DIV_1, DIV_2, DIV_8, DIV_16, DIV_64, DIV_256, DIV_1024
   } div_sel_t;

   typedef enum logic {SYNC_IDLE, SYNC_WAIT} sync_state_t;

   // last prescaler count before a counter tick
   function automatic logic [PRE_W-1:0] div_terminal(input div_sel_t d);
      unique case (d)
         DIV_OFF:  div_terminal = 10'h000;
         DIV_1:    div_terminal = 10'h000;
         DIV_2:    div_terminal = 10'h001;
         DIV_8:    div_terminal = 10'h007;
         DIV_16:   div_terminal = 10'h00f;
         DIV_64:   div_terminal = 10'h03f;
         DIV_256:  div_terminal = 10'h0ff;
         DIV_1024: div_terminal = 10'h3ff;
      endcase
   endfunction : div_terminal

   // occurrences skipped between two events for a given top value
   function automatic logic [1:0] thin_limit(input logic [CNT_W-1:0] top);
      if (top == CNT_RST)
         thin_limit = THIN_TOP0;
      else if (top == 16'h0001)
         thin_limit = THIN_TOP1;
      else
         thin_limit = THIN_NONE;
   endfunction : thin_limit

endpackage : lp_rtc_pkg

// ===== hdl/ref_clock_prescaler.sv
// reference clock synchroniser, edge detector and programmable prescaler
`timescale 1ns/1ps
module ref_clock_prescaler
(
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // reference clock pin
   input  wire logic                 ref_clk_in,
   // divide selection
   input  wire lp_rtc_pkg::div_sel_t div_sel,
   // strobes
   output logic                      ref_tick,
   output logic                      count_tick
);
   import lp_rtc_pkg::*;

   logic             ref_meta_q;
   logic             ref_sync_q;
   logic             ref_prev_q;
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_d;
   logic             at_terminal;

   // one-cycle strobe per rising reference edge, 32.768 kHz or 1.024 kHz
   assign ref_tick    = ref_sync_q && !ref_prev_q; // R02
   assign at_terminal = pre_q >= div_terminal(div_sel);
   assign count_tick  = ref_tick && (div_sel != DIV_OFF) && at_terminal; // R01

   always_comb
   begin
      pre_d = pre_q;
      // >= rather than == so a smaller divisor takes effect without a long wrap
      if (div_sel == DIV_OFF)
         pre_d = '0; // R01
      else if (ref_tick)
         pre_d = at_terminal ? '0 : pre_q + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_meta_q <= 1'b0;
         ref_sync_q <= 1'b0;
         ref_prev_q <= 1'b0;
         pre_q      <= '0;
      end
      else
      begin
         ref_meta_q <= ref_clk_in;
         ref_sync_q <= ref_meta_q;
         ref_prev_q <= ref_sync_q;
         pre_q      <= pre_d;
      end
   end

endmodule : ref_clock_prescaler

// ===== hdl/low_power_real_time_counter.sv
// 16-bit real time counter with byte-wide APB registers, flags, interrupts and events
//
// Operation
// R01 - divide field: 000 stops, 001 undivided, then 2, 8, 16, 64, 256, 1024
// R02 - counter input is the 32.768 kHz or 1.024 kHz reference
// R03 - 16-bit count advances on each divided reference rising edge
// R04 - count equal to match value raises compare interrupt request and event
// R05 - count equal to top value raises wrap request and event, clears count
// R06 - events thinned: top zero every third, top one every second
// R07 - sync busy reads one while count, control, top or match write pending
// R08 - count write takes effect two reference cycles after the register write
// R09 - software checks sync busy clear before writing the count
// R10 - match level field bits 3:2 enables interrupt while match flag set
// R11 - wrap level field bits 1:0 enables interrupt while wrap flag set
// R12 - match flag bit 1 set next count, cleared by vector or one
// R13 - wrap flag bit 0 set next count, cleared by vector or one
// R14 - low byte write held in latch; low byte read latches high byte
// R15 - count high byte, bits 15:8, at offset 0x09
// R16 - reserved bits read zero; software writes them as zero
// R17 - count low byte, bits 7:0, at offset 0x08
// R18 - top and match writes also take effect two reference cycles later
// R19 - match value above top value never gives compare request or event
// R20 - reference-side flags and events registered before software sees them
// R21 - reset: count, levels and flags zero, divide field stopped
`timescale 1ns/1ps
module low_power_real_time_counter
(
   // apb clock and reset
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   // apb slave
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [lp_rtc_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [lp_rtc_pkg::DATA_W-1:0]    pwdata,
   output logic      [lp_rtc_pkg::DATA_W-1:0]    prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   // reference clock pin
   input  wire logic                             ref_clk_in,
   // interrupt vector acknowledges
   input  wire logic                             match_vec_ack,
   input  wire logic                             wrap_vec_ack,
   // interrupt requests
   output logic                                  match_irq,
   output logic                                  wrap_irq,
   output logic      [lp_rtc_pkg::LVL_W-1:0]     match_irq_level,
   output logic      [lp_rtc_pkg::LVL_W-1:0]     wrap_irq_level,
   // events
   output logic                                  match_event,
   output logic                                  wrap_event
);
   import lp_rtc_pkg::*;

   // strobes from the prescaler
   logic                ref_tick;
   logic                count_tick;

   // bus decode
   logic                setup;
   logic                access;
   logic                wr_ok;
   logic                rd_ok;
   logic                addr_hit;
   logic [IDX_W-1:0]    idx;
   logic [BYTE_W-1:0]   wbyte;
   logic [CNT_W-1:0]    wide_word;
   logic                sync_start;
   logic                apply;
   logic [MASK_W-1:0]   new_mask;
   logic [BYTE_W-1:0]   rd_byte;

   // bus side state
   logic [DATA_W-1:0]   prdata_q,   prdata_d;
   logic                err_q,      err_d;
   logic [BYTE_W-1:0]   latch_q,    latch_d;
   logic [2*LVL_W-1:0]  irq_lvl_q,  irq_lvl_d;
   div_sel_t            ctrl_s_q,   ctrl_s_d;
   logic [CNT_W-1:0]    cnt_s_q,    cnt_s_d;
   logic [CNT_W-1:0]    top_s_q,    top_s_d;
   logic [CNT_W-1:0]    match_s_q,  match_s_d;
   logic [MASK_W-1:0]   mask_q,     mask_d;
   sync_state_t         sync_q,     sync_d;
   logic [1:0]          sync_cnt_q, sync_cnt_d;

   // counting side state
   div_sel_t            div_q,      div_d;
   logic [CNT_W-1:0]    cnt_q,      cnt_d;
   logic [CNT_W-1:0]    top_q,      top_d;
   logic [CNT_W-1:0]    match_q,    match_d;
   logic                wrap_hit;
   logic                match_hit;

   // flags and events
   logic                match_flag_q, match_flag_d;
   logic                wrap_flag_q,  wrap_flag_d;
   logic                match_clr;
   logic                wrap_clr;
   logic [1:0]          thin_match_q, thin_match_d;
   logic [1:0]          thin_wrap_q,  thin_wrap_d;
   logic                match_evt_q,  match_evt_d;
   logic                wrap_evt_q,   wrap_evt_d;

   ref_clock_prescaler u_prescaler
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .ref_clk_in (ref_clk_in),
      .div_sel    (div_q),
      .ref_tick   (ref_tick),
      .count_tick (count_tick)
   );

   // zero wait states: data and error are prepared in the setup cycle
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = err_q;

   assign setup     = psel && !penable;
   assign access    = psel && penable;
   assign wr_ok     = access && pwrite && !err_q;
   assign rd_ok     = access && !pwrite && !err_q;
   assign idx       = paddr[IDX_LSB +: IDX_W];
   assign wbyte     = pwdata[BYTE_W-1:0]; // R16
   assign wide_word = {wbyte, latch_q}; // R14

   always_comb
   begin
      addr_hit = (paddr[IDX_LSB-1:0] == '0) && (paddr[ADDR_W-1:IDX_LSB+IDX_W] == '0)
                 && (idx inside {IDX_CTRL, IDX_STATUS, IDX_IRQ_LVL, IDX_FLAGS, IDX_LATCH,
                                 IDX_CNT_LO, IDX_CNT_HI, IDX_TOP_LO, IDX_TOP_HI,
                                 IDX_MATCH_LO, IDX_MATCH_HI});
      new_mask = '0;
      if (wr_ok)
      begin
         new_mask[MASK_CTRL]  = (idx == IDX_CTRL);
         new_mask[MASK_CNT]   = (idx == IDX_CNT_HI);
         new_mask[MASK_TOP]   = (idx == IDX_TOP_HI);
         new_mask[MASK_MATCH] = (idx == IDX_MATCH_HI);
      end
      sync_start = |new_mask;
      apply      = (sync_q == SYNC_WAIT) && ref_tick && (sync_cnt_q == SYNC_LAST);
   end

   // read data; reserved bits stay zero, high bytes come from the latch
   always_comb
   begin
      rd_byte = '0;
      case (idx)
         IDX_CTRL:     rd_byte = BYTE_W'(ctrl_s_q);
         IDX_STATUS:   rd_byte[BUSY_BIT] = (sync_q != SYNC_IDLE); // R07
         IDX_IRQ_LVL:  rd_byte = BYTE_W'(irq_lvl_q);
         IDX_FLAGS:    rd_byte = BYTE_W'({match_flag_q, wrap_flag_q});
         IDX_LATCH:    rd_byte = latch_q;
         IDX_CNT_LO:   rd_byte = cnt_q[BYTE_W-1:0]; // R17
         IDX_TOP_LO:   rd_byte = top_s_q[BYTE_W-1:0];
         IDX_MATCH_LO: rd_byte = match_s_q[BYTE_W-1:0];
         IDX_CNT_HI,
         IDX_TOP_HI,
         IDX_MATCH_HI: rd_byte = latch_q; // R15
         default:      rd_byte = '0;
      endcase
   end

   // bus side next state
   always_comb
   begin
      prdata_d   = prdata_q;
      err_d      = err_q;
      latch_d    = latch_q;
      irq_lvl_d  = irq_lvl_q;
      ctrl_s_d   = ctrl_s_q;
      cnt_s_d    = cnt_s_q;
      top_s_d    = top_s_q;
      match_s_d  = match_s_q;
      mask_d     = mask_q;
      sync_d     = sync_q;
      sync_cnt_d = sync_cnt_q;
      if (setup)
      begin
         prdata_d = DATA_W'(rd_byte); // R16
         err_d    = !addr_hit;
      end
      if (wr_ok)
      begin
         unique case (idx)
            IDX_CTRL:     ctrl_s_d  = div_sel_t'(wbyte[DIV_W-1:0]); // R01
            IDX_IRQ_LVL:  irq_lvl_d = wbyte[2*LVL_W-1:0]; // R10 R11
            IDX_LATCH,
            IDX_CNT_LO,
            IDX_TOP_LO,
            IDX_MATCH_LO: latch_d   = wbyte; // R14
            IDX_CNT_HI:   cnt_s_d   = wide_word;
            IDX_TOP_HI:   top_s_d   = wide_word;
            IDX_MATCH_HI: match_s_d = wide_word;
            default:      ;
         endcase
      end
      if (rd_ok)
      begin
         unique case (idx)
            IDX_CNT_LO:   latch_d = cnt_q[CNT_W-1:BYTE_W]; // R14
            IDX_TOP_LO:   latch_d = top_s_q[CNT_W-1:BYTE_W];
            IDX_MATCH_LO: latch_d = match_s_q[CNT_W-1:BYTE_W];
            default:      ;
         endcase
      end
      // a write during a pending sync restarts the wait and keeps older writes
      if (apply)
      begin
         sync_d = SYNC_IDLE;
         mask_d = '0;
      end
      else if ((sync_q == SYNC_WAIT) && ref_tick)
         sync_cnt_d = sync_cnt_q + 1'b1; // R08 R18
      if (sync_start)
      begin
         sync_d     = SYNC_WAIT; // R07 R09
         sync_cnt_d = '0;
         mask_d     = (apply ? '0 : mask_q) | new_mask;
      end
   end

   // counting side next state
   always_comb
   begin
      div_d     = (apply && mask_q[MASK_CTRL])  ? ctrl_s_q  : div_q;
      top_d     = (apply && mask_q[MASK_TOP])   ? top_s_q   : top_q; // R18
      match_d   = (apply && mask_q[MASK_MATCH]) ? match_s_q : match_q; // R18
      wrap_hit  = count_tick && (cnt_q == top_q); // R05
      match_hit = count_tick && (cnt_q == match_q) && (match_q <= top_q); // R04 R19
      cnt_d     = cnt_q;
      if (apply && mask_q[MASK_CNT])
         cnt_d = cnt_s_q; // R08
      else if (wrap_hit)
         cnt_d = CNT_RST; // R05
      else if (count_tick)
         cnt_d = cnt_q + 1'b1; // R03
   end

   // flags, events and requests; set wins over a clear in the same cycle
   always_comb
   begin
      match_clr    = (wr_ok && (idx == IDX_FLAGS) && wbyte[MATCH_FLAG_BIT]) || match_vec_ack;
      wrap_clr     = (wr_ok && (idx == IDX_FLAGS) && wbyte[WRAP_FLAG_BIT]) || wrap_vec_ack;
      match_flag_d = (match_flag_q && !match_clr) || match_hit; // R12
      wrap_flag_d  = (wrap_flag_q && !wrap_clr) || wrap_hit; // R13
      thin_match_d = thin_match_q;
      thin_wrap_d  = thin_wrap_q;
      match_evt_d  = 1'b0;
      wrap_evt_d   = 1'b0;
      if (match_hit)
      begin
         if (thin_match_q >= thin_limit(top_q))
         begin
            match_evt_d  = 1'b1; // R04 R06
            thin_match_d = '0;
         end
         else
            thin_match_d = thin_match_q + 1'b1;
      end
      if (wrap_hit)
      begin
         if (thin_wrap_q >= thin_limit(top_q))
         begin
            wrap_evt_d  = 1'b1; // R05 R06
            thin_wrap_d = '0;
         end
         else
            thin_wrap_d = thin_wrap_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q     <= '0;
         err_q        <= 1'b0;
         latch_q      <= LATCH_RST;
         irq_lvl_q    <= IRQ_LVL_RST; // R21
         ctrl_s_q     <= DIV_OFF;
         cnt_s_q      <= CNT_RST;
         top_s_q      <= TOP_RST;
         match_s_q    <= MATCH_RST;
         mask_q       <= '0;
         sync_q       <= SYNC_IDLE;
         sync_cnt_q   <= '0;
         div_q        <= DIV_OFF; // R21
         cnt_q        <= CNT_RST; // R21
         top_q        <= TOP_RST;
         match_q      <= MATCH_RST;
         match_flag_q <= 1'b0; // R21
         wrap_flag_q  <= 1'b0;
         thin_match_q <= '0;
         thin_wrap_q  <= '0;
         match_evt_q  <= 1'b0;
         wrap_evt_q   <= 1'b0;
      end
      else
      begin
         prdata_q     <= prdata_d;
         err_q        <= err_d;
         latch_q      <= latch_d;
         irq_lvl_q    <= irq_lvl_d;
         ctrl_s_q     <= ctrl_s_d;
         cnt_s_q      <= cnt_s_d;
         top_s_q      <= top_s_d;
         match_s_q    <= match_s_d;
         mask_q       <= mask_d;
         sync_q       <= sync_d;
         sync_cnt_q   <= sync_cnt_d;
         div_q        <= div_d;
         cnt_q        <= cnt_d;
         top_q        <= top_d;
         match_q      <= match_d;
         match_flag_q <= match_flag_d; // R20
         wrap_flag_q  <= wrap_flag_d;
         thin_match_q <= thin_match_d;
         thin_wrap_q  <= thin_wrap_d;
         match_evt_q  <= match_evt_d; // R20
         wrap_evt_q   <= wrap_evt_d;
      end
   end

   assign match_irq_level = irq_lvl_q[MATCH_LVL_LSB +: LVL_W];
   assign wrap_irq_level  = irq_lvl_q[WRAP_LVL_LSB +: LVL_W];
   assign match_irq       = match_flag_q && (match_irq_level != '0); // R10
   assign wrap_irq        = wrap_flag_q && (wrap_irq_level != '0); // R11
   assign match_event     = match_evt_q;
   assign wrap_event      = wrap_evt_q;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_count_advance: // R03
      assert property (count_tick && (cnt_q != top_q) && !(apply && mask_q[MASK_CNT])
                       |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("count did not advance on a divided tick");

   chk_wrap_clears: // R05
      assert property (count_tick && (cnt_q == top_q) && !(apply && mask_q[MASK_CNT])
                       |=> (cnt_q == '0) && wrap_flag_q)
      else $error("top match did not clear count and set wrap flag");

   chk_stopped_hold: // R01
      assert property ((div_q == DIV_OFF) && !apply |=> $stable(cnt_q))
      else $error("count moved while the divider is stopped");

   chk_match_flag_set: // R12
      assert property (count_tick && (cnt_q == match_q) && (match_q <= top_q)
                       |=> match_flag_q ##1 (match_flag_q || $past(match_clr)))
      else $error("match flag not set after compare");

   chk_match_beyond: // R19
      assert property ((match_q > top_q) && $stable(match_q) && $stable(top_q)
                       |=> !match_event)
      else $error("compare event with match above top");

   chk_event_full_rate: // R06
      assert property (count_tick && (cnt_q == top_q) && (top_q >= 16'h0002)
                       |=> wrap_event ##1 !wrap_event)
      else $error("wrap event missing at top of two or more");

   chk_busy_on_write: // R07
      assert property (sync_start |=> (sync_q == SYNC_WAIT) && (mask_q != '0))
      else $error("sync busy not raised by a synchronised write");

   chk_cnt_write_late: // R08
      assert property (apply && mask_q[MASK_CNT] |=> cnt_q == $past(cnt_s_q))
      else $error("count write not applied at second reference edge");

   chk_flag_ack_clears: // R13
      assert property (wrap_vec_ack && wrap_flag_q && !wrap_hit |=> !wrap_flag_q)
      else $error("wrap flag survived its vector acknowledge");

   chk_irq_level_gate: // R10
      assert property (match_flag_q && (irq_lvl_q[MATCH_LVL_LSB +: LVL_W] == '0)
                       |-> !match_irq)
      else $error("match interrupt with its level field zero");

   chk_read_latches: // R14
      assert property (rd_ok && (idx == IDX_CNT_LO)
                       |=> latch_q == $past(cnt_q[CNT_W-1:BYTE_W]))
      else $error("low byte read did not latch the high byte");

   chk_reserved_zero: // R16
      assert property (access && !pwrite |-> prdata[DATA_W-1:BYTE_W] == '0)
      else $error("reserved read bits not zero");

endmodule : low_power_real_time_counter

// ===== tb/low_power_real_time_counter_tb.sv
// self-checking bench for the low power real time counter
`timescale 1ns/1ps
module low_power_real_time_counter_tb;
   import lp_rtc_pkg::*;
   // reference half period in pclk cycles, kept short so the run stays brief
   localparam int REF_H = 4;
   localparam int REF_P = 2 * REF_H;
   logic        pclk, presetn, psel, penable, pwrite, ref_clk_in, m_ack, pready, pslverr;
   logic        match_irq, wrap_irq, match_event, wrap_event, err, w_ack;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [1:0]  m_lvl, w_lvl;
   int          n_errors, tests_run, cyc, n_match, m0, rc, t0, t1, k;
   logic [7:0]  rst_a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24};
   div_sel_t    dv [9] = '{DIV_1, DIV_1, DIV_1, DIV_2, DIV_8, DIV_16, DIV_64, DIV_256, DIV_1024};
   logic [15:0] tp [9] = '{16'h0000, 16'h0001, 16'h0002, 16'h0002, 16'h0002, 16'h0002,
                           16'h0002, 16'h0002, 16'h0002};
   int          occ [9] = '{3, 4, 3, 6, 24, 48, 192, 768, 3072};

   low_power_real_time_counter dut_u
   (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .ref_clk_in      (ref_clk_in),
      .match_vec_ack   (m_ack),
      .wrap_vec_ack    (w_ack),
      .match_irq       (match_irq),
      .wrap_irq        (wrap_irq),
      .match_irq_level (m_lvl),
      .wrap_irq_level  (w_lvl),
      .match_event     (match_event),
      .wrap_event      (wrap_event)
   );

   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   // free running reference, cycle stamp and match event tally
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (match_event === 1'b1)
         n_match <= n_match + 1;
      if (rc == REF_H - 1)
      begin
         rc         <= 0;
         ref_clk_in <= ~ref_clk_in;
      end
      else
         rc <= rc + 1;
   end

   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 16)
      begin
         i++;
         @(posedge pclk);
      end
      // a slave that never answers counts as a mismatch
      if (i == 16)
         n_errors++;
      r   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      check(nm, e, r);
   endtask : rd

   task sync_wait;
      int i;
      i = 0;
      apb(1'b0, 8'h04, 32'h0000_0000);
      while (r[0] !== 1'b0 && i < 100)
      begin
         i++;
         apb(1'b0, 8'h04, 32'h0000_0000);
      end
      check("sync_busy_clear", 32'h0000_0000, {31'h0, r[0]});
   endtask : sync_wait

   task wr16(input logic [7:0] a, input logic [15:0] v);
      sync_wait;
      apb(1'b1, a, {24'h00_0000, v[7:0]});
      apb(1'b1, a + 8'h04, {24'h00_0000, v[15:8]});
   endtask : wr16

   // stop, load top, match and count, then start with the given divide
   task cfg(input div_sel_t d, input logic [15:0] top, input logic [15:0] mv);
      sync_wait;
      apb(1'b1, 8'h00, 32'h0000_0000);
      wr16(8'h28, top);
      wr16(8'h30, mv);
      wr16(8'h20, 16'h0000);
      apb(1'b1, 8'h00, {29'h0000_0000, d});
      sync_wait;
   endtask : cfg

   task wait_ev(input logic sel, output int t);
      int i;
      for (i = 0; i < 60000; i++)
      begin
         @(posedge pclk);
         #1;
         if ((sel ? wrap_event : match_event) === 1'b1)
            break;
      end
      t = cyc;
      check("event_seen", 32'h0000_0001, {31'h0, i < 60000});
   endtask : wait_ev

   task stop_test;
      $display("errors %0d comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   // the divide sweep dominates, near 70k cycles; give up at 90k cycles
   initial
   begin
      #450_000;
      n_errors++;
      stop_test;
   end

   initial
   begin
      {presetn, psel, penable, pwrite, ref_clk_in, m_ack, w_ack} = 7'h00;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      {cyc, n_match, rc, n_errors, tests_run} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rst_a[i])
         rd(rst_a[i], 32'h0000_0000, "reset_value");
      apb(1'b0, 8'h18, 32'h0000_0000);
      check("unmapped_err", 32'h0000_0001, {31'h0, err});
      check("unmapped_data", 32'h0000_0000, r);
      apb(1'b1, 8'h08, 32'h0000_00ff);
      rd(8'h08, 32'h0000_000f, "irq_level");
      check("levels", 32'h0000_000f, {28'h0, m_lvl, w_lvl});
      apb(1'b1, 8'h00, 32'h0000_00f8);
      rd(8'h00, 32'h0000_0000, "ctrl_reserved");
      apb(1'b1, 8'h20, 32'h0000_0034);
      rd(8'h10, 32'h0000_0034, "latch_low_write");
      sync_wait;
      apb(1'b1, 8'h24, 32'h0000_0012);
      rd(8'h04, 32'h0000_0001, "sync_busy");
      sync_wait;
      repeat (100) @(posedge pclk);
      rd(8'h20, 32'h0000_0034, "count_low");
      rd(8'h24, 32'h0000_0012, "count_high");
      apb(1'b1, 8'h08, 32'h0000_0006);
      // the level outputs change at the access edge; look once they have settled
      #1;
      check("levels", 32'h0000_0006, {28'h0, m_lvl, w_lvl});
      cfg(DIV_8, 16'h0005, 16'h0003);
      wait_ev(1'b0, t0);
      rd(8'h20, 32'h0000_0004, "count_after_match");
      check("match_irq", 32'h0000_0001, {31'h0, match_irq});
      wait_ev(1'b1, t0);
      rd(8'h20, 32'h0000_0000, "count_after_wrap");
      check("wrap_irq", 32'h0000_0001, {31'h0, wrap_irq});
      apb(1'b1, 8'h00, 32'h0000_0000);
      sync_wait;
      rd(8'h0c, 32'h0000_0003, "flags");
      apb(1'b1, 8'h0c, 32'h0000_0001);
      rd(8'h0c, 32'h0000_0002, "flags_w1c");
      check("wrap_irq_clear", 32'h0000_0000, {31'h0, wrap_irq});
      @(posedge pclk);
      m_ack <= 1'b1;
      @(posedge pclk);
      m_ack <= 1'b0;
      rd(8'h0c, 32'h0000_0000, "flags_vec_ack");
      check("match_irq_clear", 32'h0000_0000, {31'h0, match_irq});
      // match left above top throughout the sweep, so no match event may appear
      m0 = n_match;
      for (k = 0; k < 9; k++)
      begin
         cfg(dv[k], tp[k], 16'hffff);
         wait_ev(1'b1, t0);
         wait_ev(1'b1, t1);
         check("wrap_spacing", occ[k] * REF_P, t1 - t0);
      end
      check("match_events", 32'h0000_0000, n_match - m0);
      // the sweep left the wrap flag set; the vector acknowledge must clear it
      rd(8'h0c, 32'h0000_0001, "flags_wrap_set");
      @(posedge pclk);
      w_ack <= 1'b1;
      @(posedge pclk);
      w_ack <= 1'b0;
      rd(8'h0c, 32'h0000_0000, "flags_wrap_ack");
      check("wrap_irq_ack", 32'h0000_0000, {31'h0, wrap_irq});
      stop_test;
   end
endmodule : low_power_real_time_counter_tb
